/* rtl/ptcc_regs.vh */
// Constants for the pulse timing chain control block.
// Assumes a 125 MHz hclk and an AHB-Lite master with single word transfers.
// Functional notes
// RL1: Interval bit 0 gives frequency mode, 1 gives interval mode; mode-select 1 unused.
// RL2: A stage flags error when retriggered before its current event completes.
// RL3: Period stage in frequency mode makes a 50% square wave at programmed rate.
// RL4: Period stage runs freely or starts on external trigger per three mode bits.
// RL5: Inverted period output goes to trigger output; true output triggers delay stage.
// RL6: Delay stage repeats trigger rate, shifted by the programmed delay, feeding width.
// RL7: Delay longer than the period raises the delay error.
// RL8: Width stage makes one pulse per trigger of programmed width, driving transition.
// RL9: Double-pulse mode fires the width stage on both delay output edges.
// RL10: Width longer than the period raises the width error.
// RL11: Fixed-transition mode forwards the width pulse straight to the fast output.
// RL12: Ramp charges to full on rising input, holds, discharges to zero on falling.
// RL13: Range code picks external capacitors for slow slopes, internal for fast.
// RL14: Four error flags are latched and driven to the bus only during error read.
// RL15: Control code 000 off, 001 period, 010 delay, 011 width, 100 high level.
// RL16: Period, delay, width control modes route control input to that stage.
// RL17: Level check output low in normal operation, high in self test.
// RL18: Three sub-address bits with write strobe decode one of eight load strobes.
// RL19: Each stage captures its eight control bits on its store-select strobe; the slope stage here captures only its three range bits.
// RL20: Three-bit range code picks eight decades, 0 fastest, 7 slowest.
// RL21: Error flags stay set until the error-clear strobe is issued.
`ifndef PTCC_REGS_VH
`define PTCC_REGS_VH
// ==========================================
// Register byte offsets
`define PTCC_PER_OFS 8'h00
`define PTCC_DEL_OFS 8'h04
`define PTCC_WID_OFS 8'h08
`define PTCC_SLP_OFS 8'h0C
`define PTCC_MODE_OFS 8'h10
`define PTCC_ERR_OFS 8'h14
`define PTCC_ERRCLR_OFS 8'h18
`define PTCC_TIME_OFS 8'h1C
// ==========================================
// Stage store fields
`define PTCC_F_GATE 7
`define PTCC_F_TPOS 6
`define PTCC_F_TNEG 5
`define PTCC_F_TIME 4
`define PTCC_F_MSEL 3
// Mode latch fields
`define PTCC_F_DBL 3
`define PTCC_F_FIXED 4
`define PTCC_F_SELFTEST 5
// Control codes
`define PTCC_CC_OFF 3'h0
`define PTCC_CC_PER 3'h1
`define PTCC_CC_DEL 3'h2
`define PTCC_CC_WID 3'h3
`define PTCC_CC_HIL 3'h4
// Slope range code at or above which external capacitors are used
`define PTCC_SLP_EXT_MIN 3'h4
// Reset values
`define PTCC_STORE_RST 8'h00
`define PTCC_TIME_RST 16'h0004
// Ramp full scale in ramp steps
`define PTCC_RAMP_FULL 8'hFF
`endif

/* rtl/ptcc_stage.v */
// One timing stage: frequency (square wave) or interval (triggered pulse).
// Assumes base count from the time register and a decade range code.
`include "ptcc_regs.vh"
module ptcc_stage (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Configuration
	input wire [7:0] store,
	input wire [15:0] base,
	input wire ctrl_en,
	input wire ctrl_in,
	// Chain
	input wire trig,
	output reg out_reg,
	output reg err_pulse_reg
);
	reg [31:0] cnt_reg;
	reg [31:0] len;
	wire interval;
	wire mode_ok;
	integer i;
	// Decade scaling of the base length
	always @* begin
		len = {16'h0000, base};
		for (i = 0; i < 7; i = i + 1) begin
			if (i < store[2:0])
				len = len * 32'd10; // [RL20]
		end
		if (ctrl_en && ctrl_in)
			len = len << 1; // [RL16]
		if (len == 32'd0)
			len = 32'd1;
	end
	assign interval = store[`PTCC_F_TIME]; // [RL1]
	assign mode_ok = ~store[`PTCC_F_MSEL]; // [RL1]
	// Stage counter
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= 32'h00000000;
			out_reg <= 1'b0;
			err_pulse_reg <= 1'b0;
		end else begin
			err_pulse_reg <= 1'b0;
			if (!mode_ok) begin
				out_reg <= 1'b0;
				cnt_reg <= 32'h00000000;
			end else if (!interval) begin
				// Half period toggling gives 50% duty [RL3]
				// Count only while the trigger qualifier allows it [RL4]
				if (trig) begin
					if (cnt_reg + 32'd1 >= len) begin
						cnt_reg <= 32'h00000000;
						out_reg <= ~out_reg;
					end else
						cnt_reg <= cnt_reg + 32'd1;
				end else
					out_reg <= 1'b0;
			end else if (trig) begin
				if (cnt_reg != 32'd0)
					err_pulse_reg <= 1'b1; // [RL2]
				cnt_reg <= len;
				out_reg <= 1'b1;
			end else if (cnt_reg > 32'd1) begin
				cnt_reg <= cnt_reg - 32'd1;
			end else begin
				cnt_reg <= 32'h00000000;
				out_reg <= 1'b0;
			end
		end
	end
endmodule

/* rtl/ptcc_top.v */
// Timing chain control: period, delay, width and slope stages with AHB-Lite registers.
// Assumes one AHB-Lite master doing single 32-bit transfers; hclk at 125 MHz.
//
// Chosen here: the register addresses and register access over AHB-Lite.
`include "ptcc_regs.vh"
module ptcc_top (
	// AHB-Lite
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	// Pins
	input wire ext_trigger,
	input wire ctrl_input,
	output wire trigger_output,
	output reg fast_pulse_output,
	output reg [7:0] ramp_level,
	output wire ext_cap_select,
	output wire high_level_ctrl,
	output wire level_check_output
);
	// ==========================================
	// Bus decode
	reg [7:0] addr_reg;
	reg wr_reg;
	reg rd_reg;
	wire acc;
	assign acc = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// Address phase capture
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_reg <= 8'h00;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
		end else begin
			addr_reg <= haddr;
			wr_reg <= acc && hwrite;
			rd_reg <= acc && !hwrite;
		end
	end
	// One-of-eight load strobe decode
	function [7:0] ptcc_dec;
		input [7:0] a;
		input en;
		begin
			ptcc_dec = en ? (8'h01 << a[4:2]) : 8'h00; // [RL18]
		end
	endfunction
	wire [7:0] ld;
	assign ld = ptcc_dec(addr_reg, wr_reg);
	// ==========================================
	// Stores
	reg [7:0] per_store_reg;
	reg [7:0] del_store_reg;
	reg [7:0] wid_store_reg;
	reg [2:0] slope_range_reg;
	reg [7:0] mode_reg;
	reg [15:0] time_reg;
	// Stage stores load on their strobes
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			per_store_reg <= `PTCC_STORE_RST;
			del_store_reg <= `PTCC_STORE_RST;
			wid_store_reg <= `PTCC_STORE_RST;
			slope_range_reg <= 3'h0;
			mode_reg <= `PTCC_STORE_RST;
			time_reg <= `PTCC_TIME_RST;
		end else begin
			if (ld[0])
				per_store_reg <= hwdata[7:0]; // [RL19]
			if (ld[1])
				del_store_reg <= hwdata[7:0]; // [RL19]
			if (ld[2])
				wid_store_reg <= hwdata[7:0]; // [RL19]
			if (ld[3])
				slope_range_reg <= hwdata[2:0]; // [RL13]
			if (ld[4])
				mode_reg <= hwdata[7:0];
			if (ld[7])
				time_reg <= hwdata[15:0];
		end
	end
	// ==========================================
	// Control routing
	wire [2:0] ctrl_code;
	assign ctrl_code = mode_reg[2:0];
	wire per_ctl = (ctrl_code == `PTCC_CC_PER); // [RL15]
	wire del_ctl = (ctrl_code == `PTCC_CC_DEL); // [RL15]
	wire wid_ctl = (ctrl_code == `PTCC_CC_WID); // [RL15]
	assign high_level_ctrl = (ctrl_code == `PTCC_CC_HIL) && ctrl_input; // [RL15]
	assign level_check_output = mode_reg[`PTCC_F_SELFTEST]; // [RL17]
	// ==========================================
	// Period stage trigger qualification
	reg ext_d_reg;
	reg per_trig;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ext_d_reg <= 1'b0;
		else
			ext_d_reg <= ext_trigger;
	end
	// Free run when no trigger bit set, else gate or edge trigger
	always @* begin
		if (per_store_reg[7:5] == 3'h0)
			per_trig = 1'b1; // [RL4]
		else if (per_store_reg[`PTCC_F_GATE])
			per_trig = ext_trigger; // [RL4]
		else
			per_trig = (per_store_reg[`PTCC_F_TPOS] && ext_trigger && !ext_d_reg) ||
				(per_store_reg[`PTCC_F_TNEG] && !ext_trigger && ext_d_reg); // [RL4]
	end
	wire per_out;
	wire del_out;
	wire wid_out;
	wire per_err;
	wire del_err;
	wire wid_err;
	reg per_d_reg;
	reg del_d_reg;
	// Period stage
	ptcc_stage u_per (
		.hclk(hclk),
		.hresetn(hresetn),
		.store(per_store_reg),
		.base(time_reg),
		.ctrl_en(per_ctl),
		.ctrl_in(ctrl_input),
		.trig(per_trig),
		.out_reg(per_out),
		.err_pulse_reg(per_err)
	);
	assign trigger_output = ~per_out; // [RL5]
	// Delay triggered by rising edge of true period output
	wire del_trig = per_out && !per_d_reg; // [RL5]
	ptcc_stage u_del (
		.hclk(hclk),
		.hresetn(hresetn),
		.store(del_store_reg),
		.base(time_reg),
		.ctrl_en(del_ctl),
		.ctrl_in(ctrl_input),
		.trig(del_trig),
		.out_reg(del_out),
		.err_pulse_reg(del_err)
	); // [RL6] [RL7]
	// Width fires on delay falling edge, or both edges in double-pulse
	wire del_fall = !del_out && del_d_reg; // [RL6]
	wire del_rise = del_out && !del_d_reg;
	wire wid_trig = del_fall || (mode_reg[`PTCC_F_DBL] && del_rise); // [RL9]
	ptcc_stage u_wid (
		.hclk(hclk),
		.hresetn(hresetn),
		.store(wid_store_reg),
		.base(time_reg),
		.ctrl_en(wid_ctl),
		.ctrl_in(ctrl_input),
		.trig(wid_trig),
		.out_reg(wid_out),
		.err_pulse_reg(wid_err)
	); // [RL8] [RL10]
	// Edge history
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			per_d_reg <= 1'b0;
			del_d_reg <= 1'b0;
		end else begin
			per_d_reg <= per_out;
			del_d_reg <= del_out;
		end
	end
	// ==========================================
	// Transition stage
	reg slope_err;
	reg wid_d_reg;
	assign ext_cap_select = (slope_range_reg >= `PTCC_SLP_EXT_MIN); // [RL13]
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_pulse_output <= 1'b0;
			ramp_level <= 8'h00;
			slope_err <= 1'b0;
			wid_d_reg <= 1'b0;
		end else begin
			wid_d_reg <= wid_out;
			slope_err <= 1'b0;
			if (mode_reg[`PTCC_F_FIXED]) begin
				fast_pulse_output <= wid_out; // [RL11]
				ramp_level <= 8'h00;
			end else begin
				fast_pulse_output <= 1'b0;
				// Retrigger while still ramping down counts as overrun
				if (wid_out && !wid_d_reg && ramp_level != 8'h00)
					slope_err <= 1'b1; // [RL2]
				if (wid_out && ramp_level != `PTCC_RAMP_FULL)
					ramp_level <= ramp_level + 8'h01; // [RL12]
				else if (!wid_out && ramp_level != 8'h00)
					ramp_level <= ramp_level - 8'h01; // [RL12]
			end
		end
	end
	// ==========================================
	// Error latches, set wins over clear
	reg [3:0] err_reg;
	wire [3:0] err_set = {slope_err, wid_err, del_err, per_err};
	wire err_clr = ld[6]; // [RL21]
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			err_reg <= 4'h0;
		else
			err_reg <= err_set | (err_clr ? 4'h0 : err_reg); // [RL21]
	end
	// ==========================================
	// Read data, error flags only during error read
	always @* begin
		hrdata = 32'h00000000;
		if (rd_reg) begin
			case (addr_reg[4:2])
				3'h0: hrdata = {24'h000000, per_store_reg};
				3'h1: hrdata = {24'h000000, del_store_reg};
				3'h2: hrdata = {24'h000000, wid_store_reg};
				3'h3: hrdata = {29'h00000000, slope_range_reg};
				3'h4: hrdata = {24'h000000, mode_reg};
				3'h5: hrdata = {28'h0000000, err_reg}; // [RL14]
				3'h7: hrdata = {16'h0000, time_reg};
				default: hrdata = 32'h00000000;
			endcase
		end
	end
endmodule

/* tb/ptcc_sva.sv */
// Port checker for the timing chain control block.
// Assumes a bind onto ptcc_top; sees only its ports.
module ptcc_sva (
	// Bus
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	// Pins
	input wire ctrl_input,
	input wire [7:0] ramp_level,
	input wire ext_cap_select,
	input wire high_level_ctrl,
	input wire level_check_output
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rd_ph;
	logic wr_ph;
	logic [7:0] ph_addr;
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// ====
	// Data phase tracking
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_ph <= 1'b0;
			wr_ph <= 1'b0;
			ph_addr <= 8'h00;
		end else begin
			rd_ph <= hsel & hready & htrans[1] & ~hwrite;
			wr_ph <= hsel & hready & htrans[1] & hwrite;
			ph_addr <= haddr;
		end
	end
	// ====
	// Properties
	property p_ready; hreadyout && !hresp; endproperty
	a_ready: assert property (p_ready) else $error("bus stall");
	property p_rd_gate; !rd_ph |-> hrdata == 32'h0; endproperty
	a_rd_gate: assert property (p_rd_gate) else $error("data out of phase");
	property p_ramp_step; (ramp_level - $past(ramp_level)) inside {8'h00, 8'h01, 8'hFF}; endproperty
	a_ramp_step: assert property (p_ramp_step) else $error("ramp jump");
	property p_ramp_clamp; $past(ramp_level) == 8'hFF |-> ramp_level != 8'h00; endproperty
	a_ramp_clamp: assert property (p_ramp_clamp) else $error("ramp wrap");
	property p_hlc; high_level_ctrl |-> ctrl_input; endproperty
	a_hlc: assert property (p_hlc) else $error("level ctrl w/o input");
	property p_hlc_rise; $rose(high_level_ctrl) |-> $rose(ctrl_input) || $past(wr_ph); endproperty
	a_hlc_rise: assert property (p_hlc_rise) else $error("level ctrl rose");
	property p_lco; $changed(level_check_output) |-> $past(wr_ph) && $past(ph_addr) == 8'h10;
	endproperty
	a_lco: assert property (p_lco) else $error("check output moved");
	property p_cap; $changed(ext_cap_select) |-> $past(wr_ph) && $past(ph_addr) == 8'h0C;
	endproperty
	a_cap: assert property (p_cap) else $error("cap select moved");
endmodule

/* tb/ptcc_host.sv */
// Processor model: single word AHB-Lite master.
// Assumes hready is the block's hreadyout.
module ptcc_host (
	// Clock
	input wire hclk,
	// Request
	output logic hsel,
	output logic [7:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	// Answer
	input wire hready,
	input wire [31:0] hrdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// ====
	// Idle bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// One transfer; called just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output bit to);
		int n;
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		n = 0;
		do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1 && ++n < 100);
		q = hrdata;
		to = n >= 50;
		#1;
	endtask
endmodule

/* tb/ptcc_tb_top.sv */
// Bench for the timing chain control block.
// Assumes the host model and the port checker beside the design.
module ptcc_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_trigger, ctrl_input;
	logic trigger_output, fast_pulse_output, ext_cap_select, high_level_ctrl, level_check_output;
	logic [7:0] haddr, ramp_level;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, q;
	int n_fail, checks_done, th, fr, i;
	logic [7:0] rm;
	ptcc_top ptcc_top_i (.*, .hready(hreadyout));
	ptcc_host ptcc_host_i (.*, .hready(hreadyout));
	// ====
	// Clock
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		bit to;
		ptcc_host_i.xfer(w, a, d, q, to);
		if (to) begin
			n_fail++;
			finish_test();
		end
	endtask
	// Trigger high time, fast pulse count and ramp peak
	task automatic watch(input int c);
		logic pf;
		th = 0;
		fr = 0;
		rm = 8'h00;
		pf = fast_pulse_output;
		repeat (c) begin
			@(posedge hclk);
			th += (trigger_output === 1'b1);
			fr += (fast_pulse_output === 1'b1 && pf === 1'b0);
			pf = fast_pulse_output;
			if (ramp_level > rm) rm = ramp_level;
		end
		#1;
	endtask
	// ====
	// Main sequence
	initial begin
		hresetn = 1'b0;
		ext_trigger = 1'b0;
		ctrl_input = 1'b0;
		repeat (12) @(posedge hclk);
		cmp("trig_out_rst", 32'h1, trigger_output);
		hresetn <= 1'b1;
		ctrl_input <= 1'b1;
		for (i = 0; i < 5; i++) begin
			acc(1'b1, 8'h10, i | 32'h20);
			cmp("level_check", 32'h1, level_check_output);
			cmp("high_level", i == 4, high_level_ctrl);
		end
		for (i = 0; i < 8; i++) begin
			acc(1'b1, 8'h0C, i);
			cmp("cap_select", i >= 4, ext_cap_select);
		end
		$display("test modes done");
		acc(1'b1, 8'h04, 32'h10);
		acc(1'b1, 8'h08, 32'h10);
		acc(1'b1, 8'h10, 32'h10);
		cmp("level_check", 32'h0, level_check_output);
		repeat (40) @(posedge hclk);
		acc(1'b1, 8'h18, 32'h0);
		watch(160);
		cmp("duty", 80, th);
		cmp("fast_count", 20, fr);
		acc(1'b0, 8'h14, 32'h0);
		cmp("errors_none", 32'h0, q);
		acc(1'b1, 8'h10, 32'h11);
		watch(160);
		cmp("fast_ctrl", 10, fr);
		acc(1'b1, 8'h10, 32'h00);
		watch(160);
		cmp("fast_ramp_mode", 0, fr);
		cmp("ramp_seen", 1, rm != 8'h00);
		$display("test chain done");
		acc(1'b1, 8'h04, 32'h11);
		repeat (100) @(posedge hclk);
		acc(1'b0, 8'h14, 32'h0);
		cmp("delay_error", 1, q[1]);
		acc(1'b1, 8'h00, 32'h40);
		repeat (100) @(posedge hclk);
		acc(1'b0, 8'h14, 32'h0);
		cmp("error_held", 1, q[1]);
		acc(1'b1, 8'h18, 32'h0);
		acc(1'b0, 8'h14, 32'h0);
		cmp("error_cleared", 32'h0, q);
		acc(1'b0, 8'h18, 32'h0);
		cmp("unmapped_read", 32'h0, q);
		$display("test errors done");
		finish_test();
	end
endmodule
bind ptcc_top ptcc_sva ptcc_sva_i (.*);
